// [pcr_top.sv]
// Function
// - first capability pointer is read-only and always reads 48h.
// - subsystem_vendor_ident ignores config writes; loaded by eeprom or alias path.
// - subsystem_ident ignores config writes; loaded by eeprom or alias path.
// - both subsystem ids clear to zero on link, global or power-on reset.
// - power management power_mgmt_cap_ident is read-only and reads 01h.
// - second capability pointer is read-only and always reads 50h.
// - capabilities word is read-only; its default shows all fixed fields.
// - wake state mask bits 15:11 read zero.
// - state two capable bit 10 reads one.
// - state one capable bit 9 reads one.
// - auxiliary current field bits 8:6 reads zero.
// - device specific init bit 5 and reserved bit 4 read zero.
// - wake needs clock bit 3 reads zero.
// - revision field reads 010b with select clear, 011b with select set.
// - revision select is bit 26 of the general control register at D4h.
`timescale 1ns/10ps
`default_nettype none

module pcr_top (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        link_reset_n,
  input  wire logic        global_reset_in,
  input  wire logic        cfg_req,
  input  wire logic        cfg_we,
  input  wire logic [5:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic             cfg_ack,
  output logic [31:0]      cfg_rdata,
  input  wire logic        id_wr_vendor,
  input  wire logic        id_wr_ident,
  input  wire logic [15:0] id_wr_data,
  output logic             revision_select_bit
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic        rev_sel;
  } pcr_core_t;

  pcr_core_t   st_q;
  pcr_core_t   st_d;
  logic [15:0] caps;
  logic [31:0] rword;

  pcr_acc_if acc ();

  // ----------------------------------------------------------------
  // request stage and identification store
  // ----------------------------------------------------------------
  pcr_cfg_port u_port (
    .clk       (clk),
    .arst_n    (arst_n),
    .cfg_req   (cfg_req),
    .cfg_we    (cfg_we),
    .cfg_addr  (cfg_addr),
    .cfg_be    (cfg_be),
    .cfg_wdata (cfg_wdata),
    .acc       (acc.port)
  );

  pcr_id_store u_ids (
    .clk             (clk),
    .arst_n          (arst_n),
    .link_reset_n    (link_reset_n),
    .global_reset_in (global_reset_in),
    .id_wr_vendor    (id_wr_vendor),
    .id_wr_ident     (id_wr_ident),
    .id_wr_data      (id_wr_data),
    .acc             (acc.store)
  );

  // ----------------------------------------------------------------
  // capabilities word and read mux
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    caps = '0;
    caps[pcr_pkg::WAKE_LSB +: pcr_pkg::WAKE_W] = pcr_pkg::VAL_WAKE;
    caps[pcr_pkg::TWO_BIT]  = 1'b1;
    caps[pcr_pkg::ONE_BIT]  = 1'b1;
    caps[pcr_pkg::AUX_LSB +: pcr_pkg::AUX_W] = pcr_pkg::VAL_AUX;
    caps[pcr_pkg::DSI_BIT]  = 1'b0;
    caps[pcr_pkg::RSVD_BIT] = 1'b0;
    caps[pcr_pkg::WCLK_BIT] = 1'b0;
    // revision follows the select bit live, no latch of its own
    caps[pcr_pkg::REV_LSB +: pcr_pkg::REV_W] =
      st_q.rev_sel ? pcr_pkg::REV_1_2 : pcr_pkg::REV_1_1;

    // bytes of these dwords owned by other blocks read as zero here
    rword = '0;
    if (pcr_pkg::dw_hit(acc.dw, pcr_pkg::OFF_NEXT_ONE)) begin
      rword[pcr_pkg::lsb(pcr_pkg::OFF_NEXT_ONE) +: 8] = pcr_pkg::VAL_NEXT_ONE;
    end
    if (pcr_pkg::dw_hit(acc.dw, pcr_pkg::OFF_SS_VEND)) begin
      rword[pcr_pkg::lsb(pcr_pkg::OFF_SS_VEND) +: 16]  = acc.ss_vend;
      rword[pcr_pkg::lsb(pcr_pkg::OFF_SS_IDENT) +: 16] = acc.ss_ident;
    end
    if (pcr_pkg::dw_hit(acc.dw, pcr_pkg::OFF_CAP_ID)) begin
      rword[pcr_pkg::lsb(pcr_pkg::OFF_CAP_ID) +: 8]   = pcr_pkg::VAL_CAP_ID;
      rword[pcr_pkg::lsb(pcr_pkg::OFF_NEXT_TWO) +: 8] = pcr_pkg::VAL_NEXT_TWO;
      rword[pcr_pkg::lsb(pcr_pkg::OFF_PM_CAPS) +: 16] = caps;
    end
    if (pcr_pkg::dw_hit(acc.dw, pcr_pkg::OFF_GEN_CTRL)) begin
      rword[pcr_pkg::REV_SEL_BIT] = st_q.rev_sel;
    end

    // every request is answered, writes included, two edges after it
    st_d.ack   = acc.rd || acc.wr;
    st_d.rdata = acc.rd ? rword : '0;

    // only the select bit is writable; all else here drops writes
    if (acc.wr && pcr_pkg::dw_hit(acc.dw, pcr_pkg::OFF_GEN_CTRL) &&
        acc.be[pcr_pkg::REV_SEL_BIT / 8]) begin
      st_d.rev_sel = acc.wdata[pcr_pkg::REV_SEL_BIT];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q.ack     <= 1'b0;
      st_q.rdata   <= '0;
      st_q.rev_sel <= pcr_pkg::RST_REV_SEL;
    end else begin
      st_q <= st_d;
    end
  end

  assign cfg_ack             = st_q.ack;
  assign cfg_rdata           = st_q.rdata;
  assign revision_select_bit = st_q.rev_sel;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!arst_n);

  sequence s_rd(logic [7:0] off);
    cfg_req && !cfg_we && pcr_pkg::dw_hit(cfg_addr, off);
  endsequence

  sequence s_wr(logic [7:0] off);
    cfg_req && cfg_we && pcr_pkg::dw_hit(cfg_addr, off);
  endsequence

  sequence s_caps_rd(logic sel);
    s_rd(pcr_pkg::OFF_PM_CAPS) ##1 (st_q.rev_sel == sel);
  endsequence

  sequence s_no_id_change;
    link_reset_n && !global_reset_in;
  endsequence

  // no clear and no load strobe: ids must hold through the next edge
  sequence s_ids_idle;
    link_reset_n && !global_reset_in && !id_wr_vendor && !id_wr_ident;
  endsequence

  sequence s_rd_unmapped;
    cfg_req && !cfg_we &&
    !pcr_pkg::dw_hit(cfg_addr, pcr_pkg::OFF_NEXT_ONE) &&
    !pcr_pkg::dw_hit(cfg_addr, pcr_pkg::OFF_SS_VEND) &&
    !pcr_pkg::dw_hit(cfg_addr, pcr_pkg::OFF_CAP_ID) &&
    !pcr_pkg::dw_hit(cfg_addr, pcr_pkg::OFF_GEN_CTRL);
  endsequence

  a_ptr_first_val: assert property (
    s_rd(pcr_pkg::OFF_NEXT_ONE) |-> ##2 cfg_ack && cfg_rdata[15:8] == 8'h48)
    else $error("first capability pointer wrong");

  a_vendor_ro: assert property (
    (s_no_id_change and !id_wr_vendor) |=> $stable(acc.ss_vend))
    else $error("vendor id changed without load");

  a_vendor_load: assert property (
    (s_no_id_change and id_wr_vendor) |=> acc.ss_vend == $past(id_wr_data))
    else $error("vendor id load lost");

  a_ident_ro: assert property (
    (s_no_id_change and !id_wr_ident) |=> $stable(acc.ss_ident))
    else $error("subsystem_ident changed without load");

  a_ident_readback: assert property (
    (s_rd(pcr_pkg::OFF_SS_IDENT) ##1 s_ids_idle)
    |-> ##1 cfg_rdata[31:16] == acc.ss_ident && cfg_rdata[15:0] == acc.ss_vend)
    else $error("subsystem ids not read back");

  a_ids_cleared: assert property (
    (!link_reset_n || global_reset_in) |=> acc.ss_vend == 16'h0000 &&
                                            acc.ss_ident == 16'h0000)
    else $error("subsystem ids not cleared");

  a_cap_id_val: assert property (
    s_rd(pcr_pkg::OFF_CAP_ID) |-> ##2 cfg_ack && cfg_rdata[7:0] == 8'h01)
    else $error("power_mgmt_cap_ident wrong");

  a_ptr_second_val: assert property (
    s_rd(pcr_pkg::OFF_NEXT_TWO) |-> ##2 cfg_ack && cfg_rdata[15:8] == 8'h50)
    else $error("second capability pointer wrong");

  a_caps_default: assert property (
    s_caps_rd(pcr_pkg::RST_REV_SEL) |-> ##1 cfg_rdata[31:16] == pcr_pkg::RST_PM_CAPS)
    else $error("capabilities word differs from default");

  a_wake_mask_zero: assert property (
    s_rd(pcr_pkg::OFF_PM_CAPS) |-> ##2 cfg_rdata[31:27] == 5'h00)
    else $error("wake state mask not zero");

  a_state_two_set: assert property (
    s_rd(pcr_pkg::OFF_PM_CAPS) |-> ##2 cfg_rdata[26] == 1'b1)
    else $error("state two capable not set");

  a_state_one_set: assert property (
    s_rd(pcr_pkg::OFF_PM_CAPS) |-> ##2 cfg_rdata[25] == 1'b1)
    else $error("state one capable not set");

  a_aux_zero: assert property (
    s_rd(pcr_pkg::OFF_PM_CAPS) |-> ##2 cfg_rdata[24:22] == 3'h0)
    else $error("aux current field not zero");

  a_dsi_rsvd_zero: assert property (
    s_rd(pcr_pkg::OFF_PM_CAPS) |-> ##2 cfg_rdata[21:20] == 2'h0)
    else $error("init flag or reserved bit set");

  a_wake_clk_zero: assert property (
    s_rd(pcr_pkg::OFF_PM_CAPS) |-> ##2 cfg_rdata[19] == 1'b0)
    else $error("wake needs clock set");

  a_rev_old: assert property (
    s_caps_rd(1'b0) |-> ##1 cfg_rdata[18:16] == 3'h2)
    else $error("revision not 1.1 code");

  a_rev_new: assert property (
    s_caps_rd(1'b1) |-> ##1 cfg_rdata[18:16] == 3'h3)
    else $error("revision not 1.2 code");

  a_rev_sel_write: assert property (
    (s_wr(pcr_pkg::OFF_GEN_CTRL) and cfg_be[3])
    |-> ##2 st_q.rev_sel == $past(cfg_wdata[26], 2))
    else $error("revision select not written");

  a_rev_sel_hold: assert property (
    (s_wr(pcr_pkg::OFF_GEN_CTRL) and !cfg_be[3])
    |-> ##2 $stable(st_q.rev_sel))
    else $error("revision select changed without its lane");

  a_rev_readback: assert property (
    s_rd(pcr_pkg::OFF_GEN_CTRL) |-> ##2 cfg_rdata[26] == st_q.rev_sel &&
                                      cfg_rdata[25:0] == 26'h0)
    else $error("general control readback wrong");

  a_write_done: assert property (
    (cfg_req && cfg_we) |-> ##2 cfg_ack && cfg_rdata == 32'h0)
    else $error("write not completed");

  a_ack_cause: assert property (
    cfg_ack |-> $past(cfg_req, 2))
    else $error("answer without request");

  // ----------------------------------------------------------------
  // further checks
  // ----------------------------------------------------------------
  a_ptr_first_rest: assert property (
    s_rd(pcr_pkg::OFF_NEXT_ONE) |-> ##2 cfg_rdata[31:16] == 16'h0000 &&
                                      cfg_rdata[7:0] == 8'h00)
    else $error("first pointer dword has stray bytes");

  // a config write lands one edge after its stage, so idle ids there
  a_vendor_cfg_wr: assert property (
    (s_wr(pcr_pkg::OFF_SS_VEND) ##1 s_ids_idle) |-> ##1 $stable(acc.ss_vend))
    else $error("vendor id taken from config write");

  a_ident_cfg_wr: assert property (
    (s_wr(pcr_pkg::OFF_SS_IDENT) ##1 s_ids_idle) |-> ##1 $stable(acc.ss_ident))
    else $error("subsystem_ident taken from config write");

  a_ident_load: assert property (
    (s_no_id_change and id_wr_ident) |=> acc.ss_ident == $past(id_wr_data))
    else $error("subsystem_ident load lost");

  a_clear_beats_load: assert property (
    (!link_reset_n && (id_wr_vendor || id_wr_ident))
    |=> acc.ss_vend == 16'h0000 && acc.ss_ident == 16'h0000)
    else $error("load strobe beat the clear");

  a_reset_values: assert property (
    $rose(arst_n) |-> acc.ss_vend == 16'h0000 && acc.ss_ident == 16'h0000 &&
                      st_q.rev_sel == pcr_pkg::RST_REV_SEL)
    else $error("state wrong after power-on reset");

  a_id_cap_pair: assert property (
    s_rd(pcr_pkg::OFF_CAP_ID) |-> ##2 cfg_rdata[15:0] == 16'h5001)
    else $error("capability header bytes wrong");

  a_caps_fixed: assert property (
    s_rd(pcr_pkg::OFF_PM_CAPS) |-> ##2 cfg_rdata[31:19] == 13'h00c0)
    else $error("fixed capability fields wrong");

  a_rev_sel_stable: assert property (
    !(cfg_req && cfg_we) |-> ##2 $stable(st_q.rev_sel))
    else $error("revision select moved without a write");

  a_ack_needs_req: assert property (
    !cfg_req |-> ##2 !cfg_ack)
    else $error("answer in an idle slot");

  // read data is cleared between answers, not held
  a_rdata_idle_zero: assert property (
    !cfg_ack |-> cfg_rdata == 32'h0)
    else $error("read data without answer");

  a_unmapped_zero: assert property (
    s_rd_unmapped |-> ##2 cfg_ack && cfg_rdata == 32'h0)
    else $error("unmapped dword not zero");

  a_read_acked: assert property (
    (cfg_req && !cfg_we) |-> ##2 cfg_ack)
    else $error("read not answered");

endmodule : pcr_top

`default_nettype wire

// [pcr_pkg.sv]
package pcr_pkg;

  // ----------------------------------------------------------------
  // byte offsets in configuration space
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFF_NEXT_ONE = 8'h41;
  localparam logic [7:0]  OFF_SS_VEND  = 8'h44;
  localparam logic [7:0]  OFF_SS_IDENT = 8'h46;
  localparam logic [7:0]  OFF_CAP_ID   = 8'h48;
  localparam logic [7:0]  OFF_NEXT_TWO = 8'h49;
  localparam logic [7:0]  OFF_PM_CAPS  = 8'h4a;
  localparam logic [7:0]  OFF_GEN_CTRL = 8'hd4;

  // ----------------------------------------------------------------
  // fixed and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  VAL_NEXT_ONE = 8'h48;
  localparam logic [7:0]  VAL_NEXT_TWO = 8'h50;
  localparam logic [7:0]  VAL_CAP_ID   = 8'h01;
  localparam logic [15:0] RST_SS_ID    = 16'h0000;
  localparam logic [15:0] RST_PM_CAPS  = 16'h0603;
  localparam logic        RST_REV_SEL  = 1'b1;

  // ----------------------------------------------------------------
  // capabilities word fields
  // ----------------------------------------------------------------
  localparam int          WAKE_LSB     = 11;
  localparam int          WAKE_W       = 5;
  localparam logic [4:0]  VAL_WAKE     = 5'h00;
  localparam int          TWO_BIT      = 10;
  localparam int          ONE_BIT      = 9;
  localparam int          AUX_LSB      = 6;
  localparam int          AUX_W        = 3;
  localparam logic [2:0]  VAL_AUX      = 3'h0;
  localparam int          DSI_BIT      = 5;
  localparam int          RSVD_BIT     = 4;
  localparam int          WCLK_BIT     = 3;
  localparam int          REV_LSB      = 0;
  localparam int          REV_W        = 3;
  localparam logic [2:0]  REV_1_1      = 3'h2;
  localparam logic [2:0]  REV_1_2      = 3'h3;
  localparam int          REV_SEL_BIT  = 26;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic dw_hit(input logic [5:0] dw, input logic [7:0] off);
    return dw == off[7:2];
  endfunction : dw_hit

  function automatic int lsb(input logic [7:0] off);
    return 8 * int'(off[1:0]);
  endfunction : lsb

endpackage : pcr_pkg

// [pcr_acc_if.sv]
`timescale 1ns/10ps
`default_nettype none

interface pcr_acc_if;
  logic        rd;
  logic        wr;
  logic [5:0]  dw;
  logic [3:0]  be;
  logic [31:0] wdata;
  logic [15:0] ss_vend;
  logic [15:0] ss_ident;

  modport port  (output rd, wr, dw, be, wdata);
  modport store (output ss_vend, ss_ident);
  modport core  (input rd, wr, dw, be, wdata, ss_vend, ss_ident);
endinterface : pcr_acc_if

`default_nettype wire

// [pcr_cfg_port.sv]
`timescale 1ns/10ps
`default_nettype none

module pcr_cfg_port (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        cfg_req,
  input  wire logic        cfg_we,
  input  wire logic [5:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  pcr_acc_if.port          acc
);

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [5:0]  dw;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pcr_req_t;

  pcr_req_t req_q;
  pcr_req_t req_d;

  // one request per cycle, taken whole into the pipeline stage
  always_comb begin
    req_d    = req_q;
    req_d.rd = cfg_req && !cfg_we;
    req_d.wr = cfg_req && cfg_we;
    if (cfg_req) begin
      req_d.dw    = cfg_addr;
      req_d.be    = cfg_be;
      req_d.wdata = cfg_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req_q <= '0;
    end else begin
      req_q <= req_d;
    end
  end

  assign acc.rd    = req_q.rd;
  assign acc.wr    = req_q.wr;
  assign acc.dw    = req_q.dw;
  assign acc.be    = req_q.be;
  assign acc.wdata = req_q.wdata;

endmodule : pcr_cfg_port

`default_nettype wire

// [pcr_id_store.sv]
`timescale 1ns/10ps
`default_nettype none

module pcr_id_store (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        link_reset_n,
  input  wire logic        global_reset_in,
  input  wire logic        id_wr_vendor,
  input  wire logic        id_wr_ident,
  input  wire logic [15:0] id_wr_data,
  pcr_acc_if.store         acc
);

  typedef struct packed {
    logic [15:0] vend;
    logic [15:0] ident;
  } pcr_ids_t;

  pcr_ids_t ids_q;
  pcr_ids_t ids_d;

  // loader and alias path only; config writes never reach here
  always_comb begin
    ids_d = ids_q;
    if (!link_reset_n || global_reset_in) begin
      ids_d.vend  = pcr_pkg::RST_SS_ID;
      ids_d.ident = pcr_pkg::RST_SS_ID;
    end else begin
      if (id_wr_vendor) begin
        ids_d.vend = id_wr_data;
      end
      if (id_wr_ident) begin
        ids_d.ident = id_wr_data;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ids_q <= '0;
    end else begin
      ids_q <= ids_d;
    end
  end

  assign acc.ss_vend  = ids_q.vend;
  assign acc.ss_ident = ids_q.ident;

endmodule : pcr_id_store

`default_nettype wire

// [pcr_root_model.sv]
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// requester on the link side: one-cycle request, waits for answer
// ----------------------------------------------------------------
module pcr_root_model (
  input  wire logic        clk,
  input  wire logic        cfg_ack,
  input  wire logic [31:0] cfg_rdata,
  output logic             cfg_req,
  output logic             cfg_we,
  output logic [5:0]       cfg_addr,
  output logic [3:0]       cfg_be,
  output logic [31:0]      cfg_wdata
);
  initial begin
    cfg_req   = 1'b0;
    cfg_we    = 1'b0;
    cfg_addr  = 6'h00;
    cfg_be    = 4'h0;
    cfg_wdata = 32'h0000_0000;
  end

  // qualifiers go inverse once taken, so a stale value cannot pass
  task automatic access(input logic we, input logic [5:0] addr, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd, output int lat);
    @(negedge clk);
    cfg_req   = 1'b1;
    cfg_we    = we;
    cfg_addr  = addr;
    cfg_be    = be;
    cfg_wdata = wd;
    @(negedge clk);
    cfg_req   = 1'b0;
    cfg_we    = ~we;
    cfg_addr  = ~addr;
    cfg_be    = ~be;
    cfg_wdata = ~wd;
    lat = 0;
    while (cfg_ack !== 1'b1 && lat < 8) begin
      @(negedge clk);
      lat++;
    end
    rd = cfg_rdata;
  endtask : access
endmodule : pcr_root_model

`default_nettype wire

// [pcr_top_bench.sv]
`timescale 1ns/10ps
`default_nettype none

module pcr_top_bench;
  logic        clk;
  logic        arst_n;
  logic        link_reset_n;
  logic        global_reset_in;
  logic        cfg_req;
  logic        cfg_we;
  logic [5:0]  cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata;
  logic        cfg_ack;
  logic [31:0] cfg_rdata;
  logic        id_wr_vendor;
  logic        id_wr_ident;
  logic [15:0] id_wr_data;
  logic        revision_select_bit;
  int          bad_count;
  int          cmp_count;
  int          seed;
  int          lat;
  logic        sel_e;
  logic [15:0] ven_e;
  logic [15:0] sid_e;
  logic [31:0] rd;
  logic [31:0] r;
  logic [5:0]  dws [4] = '{6'h10, 6'h11, 6'h12, 6'h35};

  pcr_top dut (
    .clk(clk), .arst_n(arst_n), .link_reset_n(link_reset_n),
    .global_reset_in(global_reset_in), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .id_wr_vendor(id_wr_vendor), .id_wr_ident(id_wr_ident),
    .id_wr_data(id_wr_data), .revision_select_bit(revision_select_bit)
  );

  pcr_root_model rc (
    .clk(clk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .cfg_req(cfg_req),
    .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // expectations and checks
  // ----------------------------------------------------------------
  function automatic logic [31:0] exp_rd(input logic [5:0] a);
    case (a)
      6'h10: return 32'h0000_4800;
      6'h11: return {sid_e, ven_e};
      6'h12: return {5'h00, 1'b1, 1'b1, 3'h0, 3'h0, sel_e ? 3'h3 : 3'h2, 16'h5001};
      6'h35: return {5'h00, sel_e, 26'h0};
      default: return 32'h0;
    endcase
  endfunction : exp_rd

  task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", what, e, g);
    end
  endtask : chk_bit

  // writes answer with zero data; only byte 3 of dword 35h takes effect
  task automatic xfer(input logic we, input logic [5:0] a, input logic [3:0] be,
                      input logic [31:0] wd);
    rc.access(we, a, be, wd, rd, lat);
    if (we && a == 6'h35 && be[3]) sel_e = wd[26];
    chk_word("ack latency", 32'h1, 32'(lat));
    chk_word($sformatf("dword %h", a), we ? 32'h0 : exp_rd(a), rd);
    chk_bit("revision select", sel_e, revision_select_bit);
  endtask : xfer

  task automatic load(input logic v, input logic [15:0] d);
    @(negedge clk);
    id_wr_vendor = v;
    id_wr_ident  = ~v;
    id_wr_data   = d;
    @(negedge clk);
    id_wr_vendor = 1'b0;
    id_wr_ident  = 1'b0;
    id_wr_data   = ~d;
    if (v) ven_e = d;
    else sid_e = d;
  endtask : load

  // clear pulse with a load strobe in the same cycle: the clear must win
  task automatic clr(input int k);
    @(negedge clk);
    link_reset_n    = (k != 0);
    global_reset_in = (k == 1);
    arst_n          = (k != 2);
    id_wr_vendor    = 1'b1;
    id_wr_data      = 16'h5a5a;
    @(negedge clk);
    link_reset_n    = 1'b1;
    global_reset_in = 1'b0;
    arst_n          = 1'b1;
    id_wr_vendor    = 1'b0;
    ven_e = 16'h0000;
    sid_e = 16'h0000;
    if (k == 2) sel_e = 1'b1;
  endtask : clr

  task automatic end_sim;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    seed            = 32'h63c94eaf;
    arst_n          = 1'b0;
    link_reset_n    = 1'b1;
    global_reset_in = 1'b0;
    id_wr_vendor    = 1'b0;
    id_wr_ident     = 1'b0;
    id_wr_data      = 16'h0000;
    bad_count       = 0;
    cmp_count       = 0;
    sel_e           = 1'b1;
    ven_e           = 16'h0000;
    sid_e           = 16'h0000;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    for (int i = 0; i < 4; i++) xfer(1'b0, dws[i], 4'h0, 32'h0);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, dws[i], 4'hf, 32'hffff_ffff);
      xfer(1'b1, dws[i], 4'hf, 32'($random(seed)));
      xfer(1'b0, dws[i], 4'h0, 32'h0);
    end
    xfer(1'b1, 6'h35, 4'h7, 32'h0);
    xfer(1'b1, 6'h35, 4'h8, 32'h0);
    xfer(1'b0, 6'h12, 4'h0, 32'h0);
    xfer(1'b1, 6'h35, 4'h8, 32'h0400_0000);
    xfer(1'b0, 6'h12, 4'h0, 32'h0);
    for (int k = 0; k < 3; k++) begin
      load(1'b1, 16'($random(seed)));
      load(1'b0, 16'($random(seed)));
      xfer(1'b0, 6'h11, 4'h0, 32'h0);
      xfer(1'b1, 6'h11, 4'hf, 32'($random(seed)));
      xfer(1'b1, 6'h35, 4'h8, 32'h0);
      clr(k);
      xfer(1'b0, 6'h11, 4'h0, 32'h0);
      xfer(1'b0, 6'h12, 4'h0, 32'h0);
    end
    repeat (80) begin
      r = $random(seed);
      if (r[15]) load(r[16], r[31:16]);
      xfer(r[10], r[1:0] != 2'h0 ? dws[r[3:2]] : r[9:4], r[14:11],
           32'($random(seed)));
    end
    end_sim();
  end

  initial begin
    #(20 * 5000);
    bad_count++;
    end_sim();
  end
endmodule : pcr_top_bench

`default_nettype wire
